// ---- hw/fifo_defs.svh ----
// Constants of the clocked FIFO: sizes, programming defaults, register map and field positions.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

`define FIFO_WIDTH 18
`define FIFO_DEPTH 1024
`define SYNC_STAGES 2

// Programming word layout and defaults.
`define PROG_OFFSET_DEFAULT 16
`define PROG_PARITY_LSB 15
`define PROG_PARITY_DEFAULT 3'h0

// Parity bit positions inside an 18-bit word.
`define PARITY_LOW_POS 8
`define PARITY_HIGH_POS 17

// Register byte addresses.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PROG 8'h08

// Field positions.
`define CTRL_CASCADED 0
`define STATUS_EF 16
`define STATUS_PROGRAMMABLE_ALMOST_FLAG_N 17
`define STATUS_HF 18
`define STATUS_IN_RESET 19
`define PROG_MODE_LSB 16

`endif

// ---- hw/fifo_pkg.sv ----
// Types shared by the clocked FIFO modules.
// Assumes fifo_defs.svh is on the include path.
`include "fifo_defs.svh"

package fifo_pkg;

    // Pins from outside the system clock domain, in one bundle for the synchroniser.
    typedef struct packed {
        logic write_clock;
        logic read_clock;
        logic write_enable_n;
        logic read_enable_n;
        logic master_reset_n;
        logic output_enable_n;
        logic [`FIFO_WIDTH-1:0] data;
    } pin_bundle_t;

    // Parity mode field: enable, generate (else check), odd (else even).
    typedef struct packed {
        logic enable;
        logic generate_mode;
        logic odd;
    } parity_mode_t;

endpackage : fifo_pkg

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous pins.
// Assumes every bit is sampled independently; the first stage feeds only the second.
`timescale 1ns/10ps

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // System side
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    // Pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_VALUE;
            pin_out <= RESET_VALUE;
        end else if (clock_enable) begin
            stage1 <= pin_in;
            pin_out <= stage1;
        end
    end

endmodule : pin_sync

// ---- hw/word_memory.sv ----
// Simple dual-port word store with a registered read port.
// Assumes the writer never targets the read address in the cycle it is read.
`timescale 1ns/10ps

module word_memory #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 1024
) (
    // System side
    input wire logic clock,
    input wire logic clock_enable,
    // Write port
    input wire logic write_en,
    input wire logic [$clog2(DEPTH)-1:0] write_addr,
    input wire logic [WIDTH-1:0] write_data,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] read_addr,
    output logic [WIDTH-1:0] read_data
);

    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge clock) begin
        if (clock_enable) begin
            if (write_en) begin
                store[write_addr] <= write_data;
            end
            read_data <= store[read_addr];
        end
    end

endmodule : word_memory

// ---- hw/clocked_fifo.sv ----
// Dual-clock 18-bit FIFO with programmable almost flags and byte parity, behind a Wishbone slave.
// Assumes write and read clocks arrive as pins far slower than clock and are sampled here.
//
// What this block does
// - Master reset empties the buffer: empty/full and almost flag low, half-full high.
// - The rising edge of master reset drives all eighteen data outputs low.
// - Each write clock edge with write enable low stores the input word.
// - Each read clock edge with read enable low presents the next stored word.
// - Output enable low drives the output register out; high releases the outputs.
// - Writes while full and reads while empty are ignored; stored words, pointers and outputs stay unchanged.
// - An empty buffer keeps the last validly read word on its outputs.
// - Write edge during master reset with write enable low loads the programming register.
// - Read edge during master reset with read enable low outputs the programming register.
// - The programmed offset sets the almost-empty and almost-full distances.
// - Unprogrammed, almost flags activate at sixteen or fewer words or free locations.
// - Three mode bits pick even or odd parity generation or checking; default off.
// - Even generation drives a byte's parity bit high when that byte has odd ones.
// - The almost flag works only when the buffer is not cascaded.
// - Empty and almost-empty flags change only on read clock edges.
// - Half-full, almost-full and full flags change only on write clock edges.
// - Opposite-clock changes show only after an edge of the flag's own clock.
// - A flag's own clock edge updates it even when its enable is high.
// - At exactly half depth, the next enabled write drives half-full low.
// - Half-full returns high only once the count falls below half.
// - Opposite operations before an update edge count; later ones wait for the next.
// - The three flags encode empty, almost empty, up to half, above half, almost full, full.
// - A latent update edge out of empty or full changes flags only.
// - When cascaded, only the device being read drives its data outputs.
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`include "fifo_defs.svh"

module clocked_fifo import fifo_pkg::*; #(
    parameter int DEPTH = `FIFO_DEPTH
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clock_enable,
    // Write port pins
    input wire logic write_clock,
    input wire logic write_enable_n,
    input wire logic [`FIFO_WIDTH-1:0] data_in,
    // Read port pins
    input wire logic read_clock,
    input wire logic read_enable_n,
    input wire logic output_enable_n,
    output logic [`FIFO_WIDTH-1:0] data_out,
    output logic data_out_oe,
    // Reset pin and flags
    input wire logic master_reset_n,
    output logic empty_full_flag_n,
    output logic programmable_almost_flag_n,
    output logic half_full_flag_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int OW = AW - 1;
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_COUNT = CW'(DEPTH / 2);
    localparam logic [OW-1:0] OFFSET_DEFAULT = OW'(`PROG_OFFSET_DEFAULT);
    localparam pin_bundle_t PIN_RESET = '{write_clock: 1'b0, read_clock: 1'b0, write_enable_n: 1'b1,
                                          read_enable_n: 1'b1, master_reset_n: 1'b0,
                                          output_enable_n: 1'b1, data: '0};

    // Synchronised pins and edge detection.
    pin_bundle_t raw_pins;
    pin_bundle_t pins;
    logic write_clock_prev;
    logic read_clock_prev;
    logic master_reset_prev;

    assign raw_pins = '{write_clock: write_clock, read_clock: read_clock, write_enable_n: write_enable_n,
                        read_enable_n: read_enable_n, master_reset_n: master_reset_n,
                        output_enable_n: output_enable_n, data: data_in};

    pin_sync #(
        .WIDTH($bits(pin_bundle_t)),
        .RESET_VALUE(PIN_RESET)
    ) u_pin_sync (
        .clock(clock),
        .rst_n(rst_n),
        .clock_enable(clock_enable),
        .pin_in(raw_pins),
        .pin_out(pins)
    );

    wire write_edge = pins.write_clock & ~write_clock_prev;
    wire read_edge = pins.read_clock & ~read_clock_prev;
    wire in_reset = ~pins.master_reset_n;
    wire reset_rise = pins.master_reset_n & ~master_reset_prev;
    wire reset_fall = ~pins.master_reset_n & master_reset_prev;

    // Buffer state.
    logic [AW-1:0] write_ptr;
    logic [AW-1:0] read_ptr;
    logic [CW-1:0] count;
    logic empty_n;
    logic almost_empty;
    logic full_n;
    logic almost_full;
    logic half_full;
    logic [OW-1:0] prog_offset;
    parity_mode_t parity_mode;
    logic [`FIFO_WIDTH-1:0] out_word;
    logic [`FIFO_WIDTH-1:0] mem_read_data;
    logic cascaded;

    // Operations; the shown flag, not the live count, decides acceptance.
    // Enables pass the same two stages as the clocks, so they line up with the edge.
    wire prog_write = write_edge & ~pins.write_enable_n & in_reset;
    wire prog_read = read_edge & ~pins.read_enable_n & in_reset;
    wire do_write = write_edge & ~pins.write_enable_n & ~in_reset & full_n;
    wire do_read = read_edge & ~pins.read_enable_n & ~in_reset & empty_n;

    wire [CW-1:0] next_count = count + CW'(do_write) - CW'(do_read);
    wire [CW-1:0] offset = CW'(prog_offset);
    wire [CW-1:0] full_mark = FULL_COUNT - offset;

    // Flag values computed from the count including this cycle's operations.
    wire next_empty_n = (next_count != '0);
    wire next_almost_empty = (next_count <= offset);
    wire next_full_n = (next_count != FULL_COUNT);
    wire next_almost_full = (next_count >= full_mark);
    // Half full holds at exactly half, so it does not chatter at the midpoint.
    wire next_half_full = (next_count > HALF_COUNT) ? 1'b1 :
                          (next_count < HALF_COUNT) ? 1'b0 : half_full;

    // Parity generation or checking on the two bytes of an outgoing word.
    function automatic logic [`FIFO_WIDTH-1:0] apply_parity(
        input logic [`FIFO_WIDTH-1:0] word,
        input parity_mode_t mode
    );
        logic [`FIFO_WIDTH-1:0] result;
        logic low_ones;
        logic high_ones;
        result = word;
        low_ones = ^word[7:0];
        high_ones = ^word[16:9];
        if (mode.enable) begin
            if (mode.generate_mode) begin
                result[`PARITY_LOW_POS] = low_ones ^ mode.odd;
                result[`PARITY_HIGH_POS] = high_ones ^ mode.odd;
            end else begin
                result[`PARITY_LOW_POS] = low_ones ^ word[`PARITY_LOW_POS] ^ mode.odd;
                result[`PARITY_HIGH_POS] = high_ones ^ word[`PARITY_HIGH_POS] ^ mode.odd;
            end
        end
        return result;
    endfunction : apply_parity

    // Program image: parity mode on the top three bits, offset below it.
    wire [`FIFO_WIDTH-1:0] prog_image = {parity_mode, `PROG_PARITY_LSB'(prog_offset)} & 18'h383ff;

    // Read data lag the pointer by a cycle; link edges are far slower than that.
    word_memory #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_memory (
        .clock(clock),
        .clock_enable(clock_enable),
        .write_en(do_write),
        .write_addr(write_ptr),
        .write_data(pins.data),
        .read_addr(read_ptr),
        .read_data(mem_read_data)
    );

    // Previous samples reset to the idle pin levels, so no false edge follows reset.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            write_clock_prev <= 1'b0;
            read_clock_prev <= 1'b0;
            master_reset_prev <= 1'b0;
        end else if (clock_enable) begin
            write_clock_prev <= pins.write_clock;
            read_clock_prev <= pins.read_clock;
            master_reset_prev <= pins.master_reset_n;
        end
    end

    // Pointers and word count.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            write_ptr <= '0;
            read_ptr <= '0;
            count <= '0;
        end else if (clock_enable) begin
            if (in_reset) begin
                write_ptr <= '0;
                read_ptr <= '0;
                count <= '0;
            end else begin
                write_ptr <= write_ptr + AW'(do_write);
                read_ptr <= read_ptr + AW'(do_read);
                count <= next_count;
            end
        end
    end

    // Read-side flags move only on read clock edges, write-side ones on write clock edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            empty_n <= 1'b0;
            almost_empty <= 1'b1;
            full_n <= 1'b1;
            almost_full <= 1'b0;
            half_full <= 1'b0;
        end else if (clock_enable) begin
            // Master reset overrides any edge, so the flags read empty all through it.
            if (in_reset) begin
                empty_n <= 1'b0;
                almost_empty <= 1'b1;
                full_n <= 1'b1;
                almost_full <= 1'b0;
                half_full <= 1'b0;
            end else begin
                if (read_edge) begin
                    empty_n <= next_empty_n;
                    almost_empty <= next_almost_empty;
                end
                if (write_edge) begin
                    full_n <= next_full_n;
                    almost_full <= next_almost_full;
                    half_full <= next_half_full;
                end
            end
        end
    end

    // Programming register: defaults restored as master reset falls.
    // Restoring on the fall lets a later program write in the same reset stick.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prog_offset <= OFFSET_DEFAULT;
            parity_mode <= `PROG_PARITY_DEFAULT;
        end else if (clock_enable) begin
            if (reset_fall) begin
                prog_offset <= OFFSET_DEFAULT;
                parity_mode <= `PROG_PARITY_DEFAULT;
            end else if (prog_write) begin
                prog_offset <= pins.data[OW-1:0];
                parity_mode <= pins.data[`PROG_PARITY_LSB +: 3];
            end
        end
    end

    // Output register; it holds its word unless a valid read replaces it.
    // A program read lands here too, so the end of master reset clears it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_word <= '0;
        end else if (clock_enable) begin
            if (reset_rise) begin
                out_word <= '0;
            end else if (prog_read) begin
                out_word <= prog_image;
            end else if (do_read) begin
                out_word <= apply_parity(mem_read_data, parity_mode);
            end
        end
    end

    // Pin outputs, registered.
    // Cascading keeps the almost flag inactive, as its distance means nothing then.
    wire next_oe = ~pins.output_enable_n & (~cascaded | ~pins.read_enable_n);
    wire next_almost_n = cascaded | ~(almost_empty | almost_full);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
            data_out_oe <= 1'b0;
            empty_full_flag_n <= 1'b0;
            programmable_almost_flag_n <= 1'b0;
            half_full_flag_n <= 1'b1;
        end else if (clock_enable) begin
            data_out <= out_word;
            data_out_oe <= next_oe;
            empty_full_flag_n <= empty_n & full_n;
            programmable_almost_flag_n <= next_almost_n;
            half_full_flag_n <= ~half_full;
        end
    end

    // Wishbone slave: one wait state, ack drops in the cycle after it is given.
    // Masking with ack stops a request still held from being taken twice.
    wire bus_request = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire hit_ctrl = (wb_adr_i == `REG_CTRL);
    wire hit_status = (wb_adr_i == `REG_STATUS);
    wire hit_prog = (wb_adr_i == `REG_PROG);
    wire ctrl_write = bus_request & wb_we_i & hit_ctrl & wb_sel_i[0];

    logic [31:0] status_word;
    logic [31:0] prog_word;
    logic [31:0] read_mux;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[CW-1:0] = count;
        status_word[`STATUS_EF] = empty_full_flag_n;
        status_word[`STATUS_PROGRAMMABLE_ALMOST_FLAG_N] = programmable_almost_flag_n;
        status_word[`STATUS_HF] = half_full_flag_n;
        status_word[`STATUS_IN_RESET] = in_reset;
        prog_word = 32'h0000_0000;
        prog_word[OW-1:0] = prog_offset;
        prog_word[`PROG_MODE_LSB +: 3] = parity_mode;
    end

    assign read_mux = hit_ctrl ? {31'h0000_0000, cascaded} :
                      hit_status ? status_word :
                      hit_prog ? prog_word : 32'h0000_0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            cascaded <= 1'b0;
        end else if (clock_enable) begin
            wb_ack_o <= bus_request;
            if (bus_request && !wb_we_i) begin
                wb_dat_o <= read_mux;
            end
            if (ctrl_write) begin
                cascaded <= wb_dat_i[`CTRL_CASCADED];
            end
        end
    end

endmodule : clocked_fifo

// ---- tb/fifo_checker_asserts.sv ----
// Concurrent checks on the clocked FIFO pins and its bus handshake.
// Assumes clock_enable stays high while the checks run.
`timescale 1ns/10ps
`include "fifo_defs.svh"

module fifo_checker (
    // System
    input wire logic clock,
    input wire logic rst_n,
    // Link pins
    input wire logic write_clock,
    input wire logic read_clock,
    input wire logic master_reset_n,
    input wire logic output_enable_n,
    input wire logic [`FIFO_WIDTH-1:0] data_out,
    input wire logic data_out_oe,
    input wire logic empty_full_flag_n,
    input wire logic programmable_almost_flag_n,
    input wire logic half_full_flag_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    // Cycles since the last raw link edge or master reset, saturating at 15.
    logic wc_q, rc_q;
    logic [3:0] wr_age, rd_age, mr_age;
    wire logic wr_rise = write_clock && !wc_q;
    wire logic rd_rise = read_clock && !rc_q;
    wire logic wr_near = wr_age <= 4'h6;
    wire logic rd_near = rd_age <= 4'h6;
    wire logic mr_near = mr_age <= 4'h8;

    function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
        return hit ? 4'h0 : (a == 4'hf ? a : a + 4'h1);
    endfunction : age

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {wc_q, rc_q} <= 2'h0;
            {wr_age, rd_age, mr_age} <= 12'hfff;
        end else begin
            {wc_q, rc_q} <= {write_clock, read_clock};
            {wr_age, rd_age, mr_age} <= {age(wr_rise, wr_age), age(rd_rise, rd_age), age(!master_reset_n, mr_age)};
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence mr_held;
        !master_reset_n [*6];
    endsequence
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    a_mr_empty: assert property (
        mr_held |-> !empty_full_flag_n && !programmable_almost_flag_n && half_full_flag_n)
        else $error("flags not empty in master reset");
    a_mr_data_low: assert property ($rose(master_reset_n) |-> ##[1:8] data_out == '0)
        else $error("outputs not cleared after master reset");
    a_oe_release: assert property (output_enable_n [*4] |-> !data_out_oe)
        else $error("outputs driven while disabled");
    a_ack_answer: assert property (req_taken |=> wb_ack_o)
        else $error("bus request not answered");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_hf_fall: assert property ($fell(half_full_flag_n) |-> wr_near)
        else $error("half full set without write edge");
    a_hf_rise: assert property ($rose(half_full_flag_n) |-> wr_near || mr_near)
        else $error("half full cleared without write edge");
    a_data_read: assert property ($changed(data_out) |-> rd_near || mr_near)
        else $error("outputs changed without read edge");
    a_ef_clocked: assert property ($changed(empty_full_flag_n) |-> rd_near || wr_near || mr_near)
        else $error("empty full flag changed without edge");
endmodule : fifo_checker

bind clocked_fifo fifo_checker i_fifo_checker (.clock, .rst_n, .write_clock, .read_clock, .master_reset_n,
    .output_enable_n, .data_out, .data_out_oe, .empty_full_flag_n, .programmable_almost_flag_n,
    .half_full_flag_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ---- tb/link_partner.sv ----
// Producer and consumer logic on the link side of the clocked FIFO.
// Assumes each task is entered right after a rising system clock edge.
`timescale 1ns/10ps

module link_partner (
    // System
    input wire logic clock,
    // Write side
    output logic write_clock,
    output logic write_enable_n,
    output logic [17:0] data_in,
    // Read side and reset
    output logic read_clock,
    output logic read_enable_n,
    output logic master_reset_n
);
    // Link clocks stand still between transfers; idle enables stay high.
    initial begin
        {write_clock, read_clock} = 2'h0;
        {write_enable_n, read_enable_n} = 2'h3;
        data_in = '0;
        master_reset_n = 1'b0;
    end

    task automatic set_mr(input logic level);
        @(posedge clock);
        master_reset_n <= level;
    endtask : set_mr

    // One link clock period of 800 ns, rising in its middle.
    task automatic edge_cycle(input logic wr, input logic en_n, input logic [17:0] d);
        @(posedge clock);
        if (wr) begin
            write_enable_n <= en_n;
            data_in <= d;
        end else begin
            read_enable_n <= en_n;
        end
        repeat (4) @(posedge clock);
        if (wr) write_clock <= 1'b1;
        else read_clock <= 1'b1;
        repeat (4) @(posedge clock);
        {write_clock, read_clock} <= 2'h0;
        {write_enable_n, read_enable_n} <= 2'h3;
        // A released bus shows the inverse of its last word.
        data_in <= ~data_in;
    endtask : edge_cycle
endmodule : link_partner

// ---- tb/tb_top.sv ----
// Self-checking bench for the clocked FIFO: programming, link traffic and register bus.
// Assumes the design, the link partner and the checker are compiled first.
`timescale 1ns/10ps
`include "fifo_defs.svh"

module tb_top import fifo_pkg::*; ;
    localparam int DEPTH = 512;
    localparam int P = 4;
    localparam parity_mode_t MODE = '{enable: 1'b1, generate_mode: 1'b1, odd: 1'b0};
    localparam logic [17:0] PROG = {MODE, 7'h00, 8'(P)};

    logic clock, rst_n, clock_enable, output_enable_n, master_reset_n;
    logic write_clock, write_enable_n, read_clock, read_enable_n;
    logic [17:0] data_in, data_out, exp_out;
    logic data_out_oe, empty_full_flag_n, programmable_almost_flag_n, half_full_flag_n;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, lfsr;
    logic empty_s, ae_s, full_s, af_s, hf_s;
    logic [17:0] q[$];
    int bad_count, samples_checked;
    parity_mode_t mode_s;

    clocked_fifo #(.DEPTH(DEPTH)) i_dut (.clock, .rst_n, .clock_enable, .write_clock, .write_enable_n,
        .data_in, .read_clock, .read_enable_n, .output_enable_n, .data_out, .data_out_oe, .master_reset_n,
        .empty_full_flag_n, .programmable_almost_flag_n, .half_full_flag_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    link_partner i_partner (.clock, .write_clock, .write_enable_n, .data_in, .read_clock,
        .read_enable_n, .master_reset_n);

    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : next_rand

    function automatic logic [17:0] shape(input logic [17:0] w);
        if (mode_s.enable) begin
            // Check mode turns each parity bit into an error bit over byte and stored bit.
            w[8] = ^w[7:0] ^ (w[8] & !mode_s.generate_mode) ^ mode_s.odd;
            w[17] = ^w[16:9] ^ (w[17] & !mode_s.generate_mode) ^ mode_s.odd;
        end
        return w;
    endfunction : shape

    // Flag pins as {half full, almost, empty or full}.
    function automatic logic [2:0] flags_exp();
        return {~hf_s, ~(ae_s | af_s), ~(empty_s | full_s)};
    endfunction : flags_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic tally_and_finish();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hf};
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb

    task automatic status();
        wb(1'b0, `REG_STATUS, 32'h0);
        check(32'(rd[9:0]), 32'(q.size()));
        check(32'(rd[18:16]), 32'(flags_exp()));
    endtask : status

    task automatic op(input logic wr, input logic en_n, input logic [17:0] d, input logic oe_n);
        output_enable_n <= oe_n;
        i_partner.edge_cycle(wr, en_n, d);
        if (wr) begin
            if (!en_n && !full_s) q.push_back(d);
            full_s = q.size() == DEPTH;
            af_s = q.size() >= DEPTH - P;
            if (q.size() > DEPTH / 2) hf_s = 1'b1;
            else if (q.size() < DEPTH / 2) hf_s = 1'b0;
        end else begin
            if (!en_n && !empty_s) exp_out = shape(q.pop_front());
            empty_s = q.size() == 0;
            ae_s = q.size() <= P;
        end
        repeat (2) @(posedge clock);
        check(32'(data_out), 32'(exp_out));
        check(32'({half_full_flag_n, programmable_almost_flag_n, empty_full_flag_n}), 32'(flags_exp()));
        check(32'(data_out_oe), 32'(!oe_n));
    endtask : op

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        {rst_n, clock_enable, output_enable_n} = 3'b011;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 7'h00;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        lfsr = 32'hc6d417ab;
        mode_s = MODE;
        {bad_count, samples_checked} = '0;
        {empty_s, ae_s, full_s, af_s, hf_s} = 5'b11000;
        exp_out = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        check(32'({half_full_flag_n, programmable_almost_flag_n, empty_full_flag_n}), 32'(flags_exp()));
        i_partner.edge_cycle(1'b0, 1'b0, '0);
        repeat (2) @(posedge clock);
        check(32'(data_out), 32'h10);
        i_partner.edge_cycle(1'b1, 1'b0, PROG);
        i_partner.edge_cycle(1'b0, 1'b0, '0);
        repeat (2) @(posedge clock);
        check(32'(data_out), 32'(PROG));
        i_partner.set_mr(1'b1);
        repeat (8) @(posedge clock);
        check(32'(data_out), 32'h0);
        // Mostly writes until full, then mostly reads until empty.
        for (int i = 0; i < 2600; i++) begin
            void'(next_rand());
            op((lfsr[1:0] != 2'b00) == (i < 1300), lfsr[4:2] == 3'h0, lfsr[31:14], lfsr[7:5] == 3'h0);
            if (i % 64 == 0) status();
        end
        op(1'b1, 1'b0, 18'h2b5c3, 1'b0);
        op(1'b0, 1'b1, 18'h0, 1'b0);
        op(1'b0, 1'b0, 18'h0, 1'b0);
        // Mid-run master reset: program odd-parity checking, then pass one word.
        i_partner.set_mr(1'b0);
        mode_s = '{enable: 1'b1, generate_mode: 1'b0, odd: 1'b1};
        i_partner.edge_cycle(1'b1, 1'b0, {mode_s, 7'h00, 8'(P)});
        i_partner.set_mr(1'b1);
        q.delete();
        {empty_s, ae_s, full_s, af_s, hf_s} = 5'b11000;
        exp_out = '0;
        repeat (8) @(posedge clock);
        op(1'b1, 1'b0, 18'h1c3a5, 1'b0);
        op(1'b0, 1'b1, 18'h0, 1'b0);
        op(1'b0, 1'b0, 18'h0, 1'b0);
        wb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, `REG_CTRL, 32'h1);
        wb(1'b0, `REG_CTRL, 32'h0);
        check(rd, 32'h1);
        repeat (6) @(posedge clock);
        check(32'(programmable_almost_flag_n), 32'h1);
        check(32'(data_out_oe), 32'h0);
        tally_and_finish();
    end
endmodule : tb_top
